// file: include/wdt_pkg.sv
/*
  Constants for the watchdog reset timer: register offsets, bit positions,
  reset values and divider taps.
  Assumes a 32-bit classic Wishbone slave port and a 25 MHz system clock.
*/
// Notes on behaviour
// RULE_01: Software rewrites control register with whole writes.
// RULE_02: Counter-enable bit changes only when bit7 written 0.
// RULE_03: Counter writes accepted only while counter-enable set.
// RULE_04: Control-enable bit changes only when bit5 written 0.
// RULE_05: Run and flag writable only with control-enable set.
// RULE_06: Run bit changes when bit3 zero and enabled.
// RULE_07: Flag changes when bit1 zero and enabled.
// RULE_08: Guard bits 7,5,3,1 always read one.
// RULE_09: Counter advances on ticks while run set.
// RULE_10: Overflow sets flag; reset or qualified write clears.
// RULE_11: Count FF plus tick wraps to 00, resets.
// RULE_12: Counter starts at zero after reset.
// RULE_13: Clock select: 1xxx picks prescaler tap, 0xxx oscillator.
// RULE_14: Clock-select upper four bits read one, unwritable.
// RULE_15: Software starts watchdog with two control writes.
// RULE_16: Internal reset lasts 256 oscillator cycles.
// RULE_17: Counting resumes from any software-written value.
// RULE_18: Oscillator-clocked watchdog runs in every mode.
// RULE_19: Taps come from free-running system clock divider.
// RULE_20: Guarded fields of one write evaluated independently.
package wdt_pkg;
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_CNT = 4'h4;
  localparam logic [3:0] ADR_CSEL = 4'h8;
  localparam int B_CWE_G = 7;
  localparam int B_CWE = 6;
  localparam int B_SWE_G = 5;
  localparam int B_SWE = 4;
  localparam int B_RUN_G = 3;
  localparam int B_RUN = 2;
  localparam int B_FLG_G = 1;
  localparam int B_FLG = 0;
  localparam int DIV_W = 13;
  localparam int TAP_BASE = 5;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [3:0] CSEL_RST = 4'hF;
  localparam logic [3:0] CSEL_HI = 4'hF;
  localparam int CSEL_OSC_BIT = 3;
  localparam logic [8:0] RST_LEN = 9'h100;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage : wdt_pkg

// file: rtl/wdt_top.sv
/*
  Watchdog reset timer: 8-bit up-counter with write-guarded control bits,
  a clock-select register and a stretched internal reset on overflow.
  Assumes a classic Wishbone master on clk_i and an oscillator tick input
  from another clock domain; that tick is synchronised here.
*/
// Added by the designer: the register addresses and the Wishbone slave port.
`timescale 1ns/1ns
module wdt_top
  import wdt_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic osc_clk_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wdt_reset_o
);
  import wdt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic ack_q;
  logic [31:0] dat_q;
  logic cwe_q, swe_q, run_q, flg_q;
  logic [7:0] cnt_q;
  logic [3:0] csel_q;
  wire req = wb_cyc_i && wb_stb_i && !ack_q;
  wire wr0 = req && wb_we_i && wb_sel_i[0];
  wire wr_ctrl = wr0 && (wb_adr_i == ADR_CTRL);
  wire wr_cnt = wr0 && (wb_adr_i == ADR_CNT) && cwe_q; // RULE_03
  wire wr_csel = wr0 && (wb_adr_i == ADR_CSEL);
  wire [7:0] wd = wb_dat_i[7:0];
  wire ctrl_ok = wr_ctrl && swe_q; // RULE_05
  wire [7:0] ctrl_rd = {1'b1, cwe_q, 1'b1, swe_q, 1'b1, run_q, 1'b1, flg_q}; // RULE_08
  wire [7:0] csel_rd = {CSEL_HI, csel_q}; // RULE_14
  wire [31:0] rd_mux = (wb_adr_i == ADR_CTRL) ? {24'h00_0000, ctrl_rd} :
                       (wb_adr_i == ADR_CNT) ? {24'h00_0000, cnt_q} :
                       (wb_adr_i == ADR_CSEL) ? {24'h00_0000, csel_rd} : RD_ZERO;

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator tick synchroniser and edge detect
  logic osc_s1_q, osc_s2_q, osc_s3_q;
  wire osc_tick = osc_s2_q && !osc_s3_q;
  always_ff @(posedge clk_i) begin
    osc_s1_q <= osc_clk_i;
    osc_s2_q <= osc_s1_q;
    osc_s3_q <= rst_i ? 1'b0 : osc_s2_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler: free-running divider, rising edge of selected tap
  logic [DIV_W-1:0] div_q;
  logic tap_q;
  wire [2:0] tap_idx = csel_q[2:0];
  wire tap_now = div_q[TAP_BASE + int'(tap_idx)];
  wire use_osc = !csel_q[CSEL_OSC_BIT]; // RULE_13 RULE_18
  wire tick = use_osc ? osc_tick : (tap_now && !tap_q); // RULE_19
  always_ff @(posedge clk_i) begin
    div_q <= rst_i ? '0 : div_q + 1'b1;
    tap_q <= rst_i ? 1'b0 : tap_now;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter and overflow
  logic [8:0] rlen_q;
  wire inc = run_q && tick; // RULE_09
  wire ovf = inc && (cnt_q == CNT_MAX) && !wr_cnt; // RULE_11
  wire [7:0] cnt_d = wr_cnt ? wd : (inc ? cnt_q + 8'h01 : cnt_q); // RULE_17 RULE_11
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= CNT_RST; // RULE_12
    end else begin
      cnt_q <= cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control/status register, each field against its own guard
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cwe_q <= 1'b0;
      swe_q <= 1'b0;
      run_q <= 1'b0;
      flg_q <= 1'b0;
      csel_q <= CSEL_RST;
    end else begin
      if (wr_ctrl && !wd[B_CWE_G]) cwe_q <= wd[B_CWE]; // RULE_02 RULE_20
      if (wr_ctrl && !wd[B_SWE_G]) swe_q <= wd[B_SWE]; // RULE_04
      if (ctrl_ok && !wd[B_RUN_G]) run_q <= wd[B_RUN]; // RULE_06
      if (ovf) begin
        flg_q <= 1'b1; // RULE_10
      end else if (ctrl_ok && !wd[B_FLG_G]) begin
        flg_q <= wd[B_FLG]; // RULE_07
      end
      if (wr_csel) csel_q <= wd[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal reset stretch, counted in oscillator ticks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rlen_q <= '0;
    end else if (ovf) begin
      rlen_q <= RST_LEN; // RULE_16
    end else if (rlen_q != 9'h000 && osc_tick) begin
      rlen_q <= rlen_q - 9'h001;
    end
  end
  always_ff @(posedge clk_i) begin
    wdt_reset_o <= rst_i ? 1'b0 : (ovf || (rlen_q > 9'h001) || (rlen_q == 9'h001 && !osc_tick));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer: one wait state
  always_ff @(posedge clk_i) begin
    ack_q <= rst_i ? 1'b0 : req;
    dat_q <= rst_i ? RD_ZERO : rd_mux;
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_cwe_guard;
    @(posedge clk_i) disable iff (rst_i) (wr_ctrl && wd[B_CWE_G]) |=> $stable(cwe_q);
  endproperty
  a_cwe_guard: assert property (p_cwe_guard) else $error("counter enable changed under guard"); // RULE_02
  property p_cnt_locked;
    @(posedge clk_i) disable iff (rst_i) (wr0 && wb_adr_i == ADR_CNT && !cwe_q && !inc) |=> $stable(cnt_q);
  endproperty
  a_cnt_locked: assert property (p_cnt_locked) else $error("counter written while locked"); // RULE_03
  property p_swe_guard;
    @(posedge clk_i) disable iff (rst_i) (wr_ctrl && wd[B_SWE_G]) |=> $stable(swe_q);
  endproperty
  a_swe_guard: assert property (p_swe_guard) else $error("control enable changed under guard"); // RULE_04
  property p_run_locked;
    @(posedge clk_i) disable iff (rst_i) !(wr_ctrl && swe_q && !wd[B_RUN_G]) |=> $stable(run_q);
  endproperty
  a_run_locked: assert property (p_run_locked) else $error("run bit changed without qualified write"); // RULE_06
  property p_guard_read;
    @(posedge clk_i) disable iff (rst_i) (req && !wb_we_i && wb_adr_i == ADR_CTRL) |=> (wb_dat_o[7:0] & 8'hAA) == 8'hAA;
  endproperty
  a_guard_read: assert property (p_guard_read) else $error("guard bits not read as one"); // RULE_08
  property p_hold;
    @(posedge clk_i) disable iff (rst_i) (!run_q && !wr_cnt) |=> $stable(cnt_q);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved while stopped"); // RULE_09
  property p_ovf;
    @(posedge clk_i) disable iff (rst_i) ovf |=> (cnt_q == CNT_RST) && flg_q && wdt_reset_o;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow did not wrap, flag and reset"); // RULE_10
  property p_csel_read;
    @(posedge clk_i) disable iff (rst_i) (req && !wb_we_i && wb_adr_i == ADR_CSEL) |=> wb_dat_o[7:4] == CSEL_HI;
  endproperty
  a_csel_read: assert property (p_csel_read) else $error("clock select upper bits not one"); // RULE_14
  property p_ack_one;
    @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");

  ////////////////////////////////////////////////////////////////////////////
  // Assertions on the run/flag lock, counting and reset stretch
  property p_ctrl_locked;
    @(posedge clk_i) disable iff (rst_i) (wr_ctrl && !swe_q && !ovf) |=> $stable(run_q) && $stable(flg_q);
  endproperty
  a_ctrl_locked: assert property (p_ctrl_locked) else $error("run or flag changed while control locked"); // RULE_05
  property p_flg_locked;
    @(posedge clk_i) disable iff (rst_i) (!(ctrl_ok && !wd[B_FLG_G]) && !ovf) |=> $stable(flg_q);
  endproperty
  a_flg_locked: assert property (p_flg_locked) else $error("flag changed without qualified write"); // RULE_07
  property p_ovf_max;
    @(posedge clk_i) disable iff (rst_i) ovf |-> (cnt_q == CNT_MAX) && run_q;
  endproperty
  a_ovf_max: assert property (p_ovf_max) else $error("overflow away from full count"); // RULE_11
  property p_cnt_wr;
    @(posedge clk_i) disable iff (rst_i) wr_cnt |=> cnt_q == $past(wd);
  endproperty
  a_cnt_wr: assert property (p_cnt_wr) else $error("counter write did not land"); // RULE_17
  property p_cnt_step;
    @(posedge clk_i) disable iff (rst_i) (inc && !wr_cnt) |=> cnt_q == $past(cnt_q) + 8'h01;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("counter did not advance by one"); // RULE_09
  property p_rst_hold;
    @(posedge clk_i) disable iff (rst_i) (rlen_q > 9'h001) |=> wdt_reset_o;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("internal reset dropped early"); // RULE_16
  property p_rst_end;
    @(posedge clk_i) disable iff (rst_i) (!ovf && rlen_q == 9'h000) |=> !wdt_reset_o;
  endproperty
  a_rst_end: assert property (p_rst_end) else $error("internal reset held too long"); // RULE_16
  property p_tap_pulse;
    @(posedge clk_i) disable iff (rst_i) (!use_osc && tick) |=> !tick;
  endproperty
  a_tap_pulse: assert property (p_tap_pulse) else $error("prescaler tick longer than one cycle"); // RULE_19
  c_rst_done: cover property (@(posedge clk_i) disable iff (rst_i) $fell(wdt_reset_o));
  c_ovf: cover property (@(posedge clk_i) disable iff (rst_i) ovf);
  c_start: cover property (@(posedge clk_i) disable iff (rst_i) $rose(run_q));
  c_cntwr: cover property (@(posedge clk_i) disable iff (rst_i) wr_cnt);
  c_osc: cover property (@(posedge clk_i) disable iff (rst_i) inc && use_osc);
endmodule : wdt_top

// file: verif/tb.sv
/*
  Self-checking bench for the watchdog reset timer: register access,
  write guards, prescaled and oscillator counting, overflow reset length.
  Assumes wdt_top with a classic Wishbone slave that acks one cycle late.
*/
`timescale 1ns/1ns
module tb;
  import wdt_pkg::*;
  logic clk_i = 0, rst_i = 1, osc_clk_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, wdt_reset_o;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h1;
  logic [1:0] od = 2'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, r;
  logic [7:0] v;
  int fails = 0, checks = 0, seed = 62, t0, n;
  wdt_top dut (.clk_i(clk_i), .rst_i(rst_i), .osc_clk_i(osc_clk_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wdt_reset_o(wdt_reset_o));
  initial forever #20 clk_i = ~clk_i;
  // Oscillator stand-in: eight system clocks a period
  always @(posedge clk_i) begin
    od <= od + 2'h1;
    if (od == 2'h3) osc_clk_i <= ~osc_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
      fails++;
    end
  endtask : chk
  task automatic rng(input int g, input int lo, input int hi);
    checks++;
    if (g < lo || g > hi) begin
      $display("unexpected at %0t: got %h expected %h to %h", $time, g, lo, hi);
      fails++;
    end
  endtask : rng
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h00_0000, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (wb_ack_o !== 1'b1) begin
      $display("unexpected at %0t: got %h expected %h", $time, wb_ack_o, 1'b1);
      fails++;
    end
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    wb(1'b0, a, 8'h00);
    chk(r, e);
  endtask : rd
  // Control byte with one guard cleared and its field set to b
  function automatic logic [7:0] ctl(input int g, input logic b);
    logic [7:0] d;
    d = 8'hAA;
    d[g] = 1'b0;
    d[g-1] = b;
    return d;
  endfunction : ctl
  task automatic end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(40 * 20000);
    fails++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ADR_CTRL, 32'h0000_00AA);
    rd(ADR_CNT, 32'h0000_0000);
    rd(ADR_CSEL, 32'h0000_00FF);
    wb(1'b1, 4'hC, 8'h5A);
    rd(4'hC, 32'h0000_0000);
    $display("reset values done");
    wb(1'b1, ADR_CTRL, 8'hFF);
    rd(ADR_CTRL, 32'h0000_00AA);
    wb(1'b1, ADR_CNT, 8'h55);
    rd(ADR_CNT, 32'h0000_0000);
    wb(1'b1, ADR_CTRL, ctl(B_RUN_G, 1'b1));
    rd(ADR_CTRL, 32'h0000_00AA);
    wb(1'b1, ADR_CTRL, ctl(B_CWE_G, 1'b1));
    rd(ADR_CTRL, 32'h0000_00EA);
    repeat (4) begin
      v = 8'($random(seed));
      wb(1'b1, ADR_CNT, v);
      rd(ADR_CNT, {24'h00_0000, v});
    end
    wb_sel_i <= 4'h0;
    wb(1'b1, ADR_CNT, ~v);
    wb_sel_i <= 4'h1;
    rd(ADR_CNT, {24'h00_0000, v});
    wb(1'b1, ADR_CTRL, ctl(B_SWE_G, 1'b1));
    rd(ADR_CTRL, 32'h0000_00FA);
    $display("write guards done");
    wb(1'b1, ADR_CSEL, 8'h08);
    rd(ADR_CSEL, 32'h0000_00F8);
    wb(1'b1, ADR_CNT, 8'h00);
    wb(1'b1, ADR_CTRL, ctl(B_RUN_G, 1'b1));
    rd(ADR_CTRL, 32'h0000_00FE);
    repeat (320) @(posedge clk_i);
    wb(1'b0, ADR_CNT, 8'h00);
    rng(int'(r), 5, 6);
    wb(1'b1, ADR_CTRL, ctl(B_RUN_G, 1'b0));
    wb(1'b0, ADR_CNT, 8'h00);
    v = r[7:0];
    repeat (200) @(posedge clk_i);
    rd(ADR_CNT, {24'h00_0000, v});
    $display("prescaler done");
    v = 8'($random(seed)) & 8'h07;
    wb(1'b1, ADR_CSEL, v);
    rd(ADR_CSEL, {24'h00_0000, 4'hF, v[3:0]});
    wb(1'b1, ADR_CNT, 8'hFE);
    wb(1'b1, ADR_CTRL, ctl(B_RUN_G, 1'b1));
    n = 0;
    while (wdt_reset_o !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    t0 = $time;
    rng(n, 1, 60);
    wb(1'b1, ADR_CTRL, ctl(B_RUN_G, 1'b0));
    rd(ADR_CTRL, 32'h0000_00FB);
    wb(1'b1, ADR_CTRL, 8'hAA);
    rd(ADR_CTRL, 32'h0000_00FB);
    wb(1'b1, ADR_CTRL, ctl(B_FLG_G, 1'b0));
    rd(ADR_CTRL, 32'h0000_00FA);
    n = 0;
    while (wdt_reset_o !== 1'b0 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    rng(($time - t0) / 40, 2040, 2056);
    $display("overflow done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({31'h0, wdt_reset_o}, 32'h0000_0000);
    rd(ADR_CTRL, 32'h0000_00AA);
    rd(ADR_CNT, 32'h0000_0000);
    rd(ADR_CSEL, 32'h0000_00FF);
    $display("second reset done");
    end_of_test();
  end
endmodule : tb
